// ===== i2crs_regs.svh
// Constants for the two-wire register slave port
`ifndef I2CRS_REGS_SVH
`define I2CRS_REGS_SVH
`define I2CRS_DEF_ADDR 7'h01
`define I2CRS_ADDR_CFG_IDX 8'h7F
`define I2CRS_PROT_LO 8'h06
`define I2CRS_PROT_HI 8'h09
`define I2CRS_PROC_NS 200
`define I2CRS_PREP_NS 100
`define I2CRS_CLK_NS 4
`define I2CRS_PROC_CYC ((`I2CRS_PROC_NS + `I2CRS_CLK_NS - 1) / `I2CRS_CLK_NS)
`define I2CRS_PREP_CYC ((`I2CRS_PREP_NS + `I2CRS_CLK_NS - 1) / `I2CRS_CLK_NS)
`define I2CRS_HALF_NS 1250
`define I2CRS_HALF_CYC (`I2CRS_HALF_NS / `I2CRS_CLK_NS)
`endif

// ===== i2crs_pkg.sv
// Types shared by both ends of the two-wire register port
package i2crs_pkg;
    typedef logic [7:0] i2crs_byte_t;
    typedef enum logic {I2CRS_WR, I2CRS_RD} i2crs_dir_t;
endpackage

// ===== i2crs_if.sv
// Bus wires between slave port and master
`timescale 1ns/1ps
interface i2crs_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic scl_s_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Open drain with pull-up: any enable pulls low
    assign scl = ~(scl_m_oe | scl_s_oe);
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport slave (input scl, input sda, output scl_s_oe, output sda_s_oe);
    modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// ===== i2crs_slave.sv
// Device end: two-wire register slave port
`timescale 1ns/1ps
`include "i2crs_regs.svh"
module i2crs_slave #(
    parameter int DEPTH = 256,
    parameter int PROC_CYC = `I2CRS_PROC_CYC,
    parameter int PREP_CYC = `I2CRS_PREP_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ext_reset_input_i,
    input wire logic setup_mode_i,
    input wire logic [9:0] pin_assign_i,
    input wire logic [9:0] pin_func_i,
    output logic [9:0] pin_out_o,
    output i2crs_pkg::i2crs_byte_t wr_data_o,
    output i2crs_pkg::i2crs_byte_t wr_index_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    i2crs_if.slave bus
);
    import i2crs_pkg::*;

    // ----------------------------------------
    // Reset, edge and condition detection
    // ----------------------------------------
    wire rst_n = resetn_i & ~ext_reset_input_i;
    logic scl_q_r, sda_q_r;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= bus.scl;
            sda_q_r <= bus.sda;
        end
    end
    wire scl_rise = bus.scl & ~scl_q_r;
    wire scl_fall = ~bus.scl & scl_q_r;
    wire start_c = scl_q_r & bus.scl & sda_q_r & ~bus.sda;
    wire stop_c = scl_q_r & bus.scl & ~sda_q_r & bus.sda;

    assign pin_out_o = pin_func_i & pin_assign_i;

    // ----------------------------------------
    // Register array and state
    // ----------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_RX, S_PROC, S_ACK, S_PREP, S_TX, S_MACK} i2crs_st_t;
    i2crs_st_t st_r;
    i2crs_byte_t mem [DEPTH];
    i2crs_byte_t sh_r, idx_r, tx_r;
    logic [6:0] addr_r;
    logic [3:0] bit_r;
    logic [1:0] phase_r; // 0 address, 1 index, 2 data
    logic dir_r, ack_r, pend_r;
    logic [15:0] cnt_r;

    // Two-entry buffer toward the user side
    i2crs_byte_t bd_r [2];
    i2crs_byte_t bi_r [2];
    logic [1:0] bcnt_r;
    logic bwp_r, brp_r;
    wire buf_full = bcnt_r == 2'd2;
    wire buf_push = st_r == S_PROC && cnt_r == 16'd0 && phase_r == 2'd2 && ack_r && !buf_full;
    wire buf_pop = wr_valid_o & wr_ready_i;
    assign wr_valid_o = bcnt_r != 2'd0;
    assign wr_data_o = bd_r[brp_r];
    assign wr_index_o = bi_r[brp_r];

    wire addr_hit = sh_r[7:1] == addr_r;
    wire prot = idx_r >= `I2CRS_PROT_LO && idx_r <= `I2CRS_PROT_HI;
    wire wr_ok = setup_mode_i | ~prot;
    // Clock held low whenever the byte is still being worked on
    wire stretch = st_r == S_PROC || st_r == S_PREP;
    wire proc_done = cnt_r == 16'd0 && !(phase_r == 2'd2 && ack_r && buf_full);

    // Release lags one cycle so the data line settles before the clock rises
    logic hold_r;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= stretch;
        end
    end
    assign bus.scl_s_oe = stretch | hold_r;
    assign bus.sda_s_oe = (st_r == S_ACK && ack_r) || (st_r == S_TX && !tx_r[7]);

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            sh_r <= 8'h00;
            idx_r <= 8'h00;
            tx_r <= 8'hFF;
            addr_r <= `I2CRS_DEF_ADDR;
            bit_r <= 4'h0;
            phase_r <= 2'd0;
            dir_r <= 1'b0;
            ack_r <= 1'b0;
            pend_r <= 1'b0;
            cnt_r <= 16'h0000;
        end else if (start_c) begin
            st_r <= S_RX;
            bit_r <= 4'h0;
            phase_r <= 2'd0;
            if (pend_r) begin
                addr_r <= mem[`I2CRS_ADDR_CFG_IDX][6:0];
                pend_r <= 1'b0;
            end
        end else if (stop_c) begin
            st_r <= S_IDLE;
            if (pend_r) begin
                addr_r <= mem[`I2CRS_ADDR_CFG_IDX][6:0];
                pend_r <= 1'b0;
            end
        end else begin
            unique case (st_r)
                S_IDLE: begin
                end
                S_RX: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], bus.sda};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'd8) begin
                        st_r <= S_PROC;
                        cnt_r <= 16'(PROC_CYC);
                        ack_r <= phase_r != 2'd0 || addr_hit;
                    end
                end
                S_PROC: begin
                    if (cnt_r != 16'd0) begin
                        cnt_r <= cnt_r - 16'd1;
                    end else if (proc_done) begin
                        st_r <= S_ACK;
                        if (phase_r == 2'd0) begin
                            dir_r <= sh_r[0];
                        end else if (phase_r == 2'd1) begin
                            idx_r <= sh_r;
                        end else if (ack_r) begin
                            if (wr_ok) begin
                                mem[idx_r] <= sh_r;
                                pend_r <= pend_r | (idx_r == `I2CRS_ADDR_CFG_IDX);
                            end
                            idx_r <= idx_r + 8'h01;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_r <= 4'h0;
                        if (!ack_r) begin
                            st_r <= S_IDLE;
                        end else if (phase_r == 2'd0 && dir_r) begin
                            st_r <= S_PREP;
                            cnt_r <= 16'(PREP_CYC);
                        end else begin
                            st_r <= S_RX;
                            phase_r <= phase_r == 2'd0 ? 2'd1 : 2'd2;
                        end
                    end
                end
                S_PREP: begin
                    if (cnt_r != 16'd0) begin
                        cnt_r <= cnt_r - 16'd1;
                    end else begin
                        tx_r <= mem[idx_r];
                        idx_r <= idx_r + 8'h01;
                        st_r <= S_TX;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + 4'h1;
                        tx_r <= {tx_r[6:0], 1'b1};
                        if (bit_r == 4'd7) begin
                            st_r <= S_MACK;
                        end
                    end
                end
                S_MACK: begin
                    // Master NAK ends the read; ACK fetches the next byte
                    if (scl_rise) begin
                        ack_r <= ~bus.sda;
                    end else if (scl_fall) begin
                        st_r <= ack_r ? S_PREP : S_IDLE;
                        cnt_r <= 16'(PREP_CYC);
                        bit_r <= 4'h0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Buffer pointers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (buf_push) begin
            bd_r[bwp_r] <= sh_r;
            bi_r[bwp_r] <= idx_r;
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= 2'd0;
            bwp_r <= 1'b0;
            brp_r <= 1'b0;
        end else begin
            bwp_r <= bwp_r ^ buf_push;
            brp_r <= brp_r ^ buf_pop;
            bcnt_r <= bcnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end
endmodule

// ===== i2crs_master.sv
// Host end: two-wire bus master issuing register writes and reads
`timescale 1ns/1ps
`include "i2crs_regs.svh"
module i2crs_master #(
    parameter int HALF_CYC = `I2CRS_HALF_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire i2crs_pkg::i2crs_dir_t req_dir_i,
    input wire logic [6:0] req_addr_i,
    input wire i2crs_pkg::i2crs_byte_t req_index_i,
    input wire i2crs_pkg::i2crs_byte_t req_data_i,
    output i2crs_pkg::i2crs_byte_t rd_data_o,
    output logic rd_valid_o,
    output logic nak_o,
    i2crs_if.master bus
);
    import i2crs_pkg::*;

    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_GAP} i2crs_mst_t;
    i2crs_mst_t st_r;
    logic [15:0] tc_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic [1:0] byte_r;
    logic [1:0] nby_r;
    logic scl_r, sda_r, rd_r, dirp_r;
    i2crs_byte_t data_r, idx_r;
    logic [6:0] addr_r;
    wire tick = tc_r == 16'd0;
    // A stretched clock freezes the bit timer until the slave lets go
    wire held = scl_r && !bus.scl;

    assign bus.scl_m_oe = ~scl_r;
    assign bus.sda_m_oe = ~sda_r;
    assign req_ready_o = st_r == M_IDLE && bus.scl;

    function automatic logic [8:0] frame(input logic [1:0] n, input logic rdp, input logic [6:0] a,
                                         input i2crs_byte_t i, input i2crs_byte_t d);
        if (n == 2'd0) begin
            frame = {a, rdp, 1'b1};
        end else if (rdp) begin
            frame = 9'h1FF;
        end else begin
            frame = {(n == 2'd1) ? i : d, 1'b1};
        end
    endfunction

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= M_IDLE;
            tc_r <= 16'h0000;
            ph_r <= 2'd0;
            bit_r <= 4'h0;
            sh_r <= 9'h1FF;
            byte_r <= 2'd0;
            nby_r <= 2'd0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            rd_r <= 1'b0;
            dirp_r <= 1'b0;
            data_r <= 8'h00;
            idx_r <= 8'h00;
            addr_r <= 7'h00;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            nak_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            if (!tick && !held) begin
                tc_r <= tc_r - 16'd1;
            end
            unique case (st_r)
                M_IDLE: begin
                    if (req_valid_i && bus.scl) begin
                        addr_r <= req_addr_i;
                        idx_r <= req_index_i;
                        data_r <= req_data_i;
                        rd_r <= req_dir_i == I2CRS_RD;
                        dirp_r <= 1'b0;
                        nak_o <= 1'b0;
                        st_r <= M_START;
                        tc_r <= 16'(HALF_CYC);
                    end
                end
                M_START: begin
                    if (tick) begin
                        sda_r <= 1'b0;
                        st_r <= M_BIT;
                        ph_r <= 2'd0;
                        bit_r <= 4'h0;
                        byte_r <= 2'd0;
                        // write sends index and data, read first sends index
                        nby_r <= dirp_r ? 2'd2 : (rd_r ? 2'd2 : 2'd3);
                        sh_r <= frame(2'd0, dirp_r, addr_r, idx_r, data_r);
                        tc_r <= 16'(HALF_CYC);
                    end
                end
                M_BIT: begin
                    if (tick && !held) begin
                        tc_r <= 16'(HALF_CYC);
                        ph_r <= ph_r + 2'd1;
                        if (ph_r == 2'd0) begin
                            scl_r <= 1'b0;
                        end else if (ph_r == 2'd1) begin
                            // Master acks read bytes except the last
                            sda_r <= bit_r == 4'd8 ? !(dirp_r && byte_r != 2'd0 && byte_r + 2'd1 != nby_r) : sh_r[8];
                        end else if (ph_r == 2'd2) begin
                            scl_r <= 1'b1;
                        end else begin
                            // sampled only once the slave has released the clock
                            sh_r <= {sh_r[7:0], bus.sda};
                            bit_r <= bit_r + 4'h1;
                            ph_r <= 2'd0;
                            if (bit_r == 4'd8) begin
                                if (dirp_r && byte_r != 2'd0) begin
                                    rd_data_o <= sh_r[7:0];
                                    rd_valid_o <= 1'b1;
                                end
                                if (!dirp_r && bus.sda || byte_r + 2'd1 == nby_r) begin
                                    nak_o <= !dirp_r && bus.sda;
                                    st_r <= M_STOP;
                                    ph_r <= 2'd0;
                                end else begin
                                    byte_r <= byte_r + 2'd1;
                                    bit_r <= 4'h0;
                                    sh_r <= frame(byte_r + 2'd1, dirp_r, addr_r, idx_r, data_r);
                                end
                            end
                        end
                    end
                end
                M_STOP: begin
                    if (tick && !held) begin
                        tc_r <= 16'(HALF_CYC);
                        ph_r <= ph_r + 2'd1;
                        if (ph_r == 2'd0) begin
                            scl_r <= 1'b0;
                        end else if (ph_r == 2'd1) begin
                            sda_r <= 1'b0;
                        end else if (ph_r == 2'd2) begin
                            scl_r <= 1'b1;
                        end else begin
                            sda_r <= 1'b1;
                            st_r <= M_GAP;
                        end
                    end
                end
                M_GAP: begin
                    if (tick) begin
                        if (rd_r && !dirp_r && !nak_o) begin
                            dirp_r <= 1'b1;
                            st_r <= M_START;
                            tc_r <= 16'(HALF_CYC);
                        end else begin
                            st_r <= M_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ===== i2crs_bus_sva.sv
// Bus-level checks on the wires between the two ends
`timescale 1ns/1ps
module i2crs_bus_sva #(
    parameter int PREP_CYC = 25
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic scl_s_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    // ----------------------------------------
    // Length of each clock hold by the slave
    // ----------------------------------------
    logic [15:0] hold_cnt_r;
    logic [15:0] hold_cnt_nxt;
    assign hold_cnt_nxt = scl_s_oe ? hold_cnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_cnt_r <= 16'h0000;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    stretch_start_a: assert property ($rose(scl_s_oe) |-> $past(scl_m_oe))
        else $error("Slave held clock outside a master low phase");
    // Back-pressure may lengthen a hold, never shorten it
    stretch_len_a: assert property ($fell(scl_s_oe) |-> hold_cnt_r >= PREP_CYC)
        else $error("Slave clock hold too short");
    slave_sda_edge_a: assert property ($changed(sda_s_oe) |-> !$past(scl))
        else $error("Slave moved data while clock high");
    ack_setup_a: assert property ($fell(scl_s_oe) |-> $stable(sda_s_oe))
        else $error("Slave data changed as clock was released");
    one_driver_a: assert property (scl |-> !(sda_s_oe && sda_m_oe))
        else $error("Both ends drive data in one clock high phase");
    no_start_ack_a: assert property (scl && $past(scl) && $past(sda_s_oe) |-> $stable(sda_m_oe))
        else $error("Master start or stop during slave acknowledge");
    start_scl_high_a: assert property ($fell(sda) && scl |-> $past(scl, 2))
        else $error("Start without clock high beforehand");
    stop_quiet_a: assert property ($rose(sda) && scl && $past(scl) |=> (!sda_s_oe && !scl_s_oe) [*4])
        else $error("Slave drove bus right after stop");
    reset_idle_a: assert property (disable iff (1'b0) !resetn_i |-> !(scl_s_oe || sda_s_oe || scl_m_oe || sda_m_oe))
        else $error("Bus driven during reset");
    hold_seen_c: cover property ($fell(scl_s_oe));
    start_seen_c: cover property ($fell(sda) && scl);
    ack_seen_c: cover property (sda_s_oe && scl);
endmodule

// ===== i2c_register_slave_port_test.sv
// Self-checking bench joining slave port and master
`timescale 1ns/1ps
`include "i2crs_regs.svh"
module i2c_register_slave_port_test;
    import i2crs_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam int PREP = `I2CRS_PREP_CYC;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b1;
    logic ext_rst = 1'b0;
    logic setup_mode = 1'b0;
    logic [9:0] pin_assign = 10'h000;
    logic [9:0] pin_func = 10'h000;
    logic wr_ready = 1'b1;
    logic req_valid = 1'b0;
    i2crs_dir_t req_dir = I2CRS_WR;
    logic [6:0] req_addr = 7'h00;
    i2crs_byte_t req_index = 8'h00;
    i2crs_byte_t req_data = 8'h00;
    logic [9:0] pin_out;
    i2crs_byte_t wr_data;
    i2crs_byte_t wr_index;
    i2crs_byte_t rd_data;
    i2crs_byte_t got;
    logic wr_valid;
    logic req_ready;
    logic rd_valid;
    logic nak;
    logic [15:0] wr_seen[$];
    logic [9:0] pa[3] = '{10'h3FF, 10'h0F0, 10'h2A5};
    logic [9:0] pf[3] = '{10'h155, 10'h3CF, 10'h3FF};
    int err_total = 0;
    int checks_done = 0;
    i2crs_if bus_if ();
    i2crs_slave i2crs_slave_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .ext_reset_input_i(ext_rst),
        .setup_mode_i(setup_mode), .pin_assign_i(pin_assign), .pin_func_i(pin_func), .pin_out_o(pin_out),
        .wr_data_o(wr_data), .wr_index_o(wr_index), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .bus(bus_if));
    i2crs_master #(.HALF_CYC(8)) i2crs_master_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_dir_i(req_dir), .req_addr_i(req_addr),
        .req_index_i(req_index), .req_data_i(req_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .nak_o(nak), .bus(bus_if));
    i2crs_bus_sva #(.PREP_CYC(PREP)) i2crs_bus_sva_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .scl_m_oe(bus_if.scl_m_oe), .sda_m_oe(bus_if.sda_m_oe), .scl_s_oe(bus_if.scl_s_oe),
        .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));
    // ----------------------------------------
    // Clock, monitor and helpers
    // ----------------------------------------
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // Sampled at negedge, so the accepting edge never races the design
    always @(negedge mclk_i) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            wr_seen.push_back({wr_index, wr_data});
        end
    end
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input string what);
        err_total++;
        $display("Error %s timed out", what);
        wrap_up();
    endtask
    // One request held until taken, then waited on until idle again
    task automatic xfer(input i2crs_dir_t dir, input logic [6:0] addr, input i2crs_byte_t idx,
                        input i2crs_byte_t dat);
        int n;
        n = 0;
        got = 8'hXX;
        @(posedge mclk_i);
        req_valid <= 1'b1;
        req_dir <= dir;
        req_addr <= addr;
        req_index <= idx;
        req_data <= dat;
        @(negedge mclk_i);
        while (req_ready !== 1'b1) begin
            if (++n > 5000) give_up("request");
            @(negedge mclk_i);
        end
        @(posedge mclk_i);
        req_valid <= 1'b0;
        n = 0;
        @(negedge mclk_i);
        while (req_ready !== 1'b1) begin
            if (rd_valid === 1'b1) got = rd_data;
            if (++n > 20000) give_up("completion");
            @(negedge mclk_i);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        // Falling edge at time zero so every asynchronous reset sees it
        resetn_i <= 1'b0;
        repeat (12) @(posedge mclk_i);
        resetn_i <= 1'b1;
        xfer(I2CRS_WR, 7'h01, 8'h10, 8'hA5);
        check("write nak", nak, 16'h0000);
        check("write count", 16'(wr_seen.size()), 16'h0001);
        check("write entry", wr_seen.pop_front(), 16'h10A5);
        xfer(I2CRS_RD, 7'h01, 8'h10, 8'h00);
        check("read data", got, 16'h00A5);
        xfer(I2CRS_WR, 7'h22, 8'h11, 8'h77);
        check("foreign nak", nak, 16'h0001);
        check("foreign count", 16'(wr_seen.size()), 16'h0000);
        @(posedge mclk_i);
        setup_mode <= 1'b1;
        xfer(I2CRS_WR, 7'h01, 8'h07, 8'h3C);
        @(posedge mclk_i);
        setup_mode <= 1'b0;
        xfer(I2CRS_WR, 7'h01, 8'h07, 8'hC3);
        xfer(I2CRS_RD, 7'h01, 8'h07, 8'h00);
        check("protected data", got, 16'h003C);
        @(posedge mclk_i);
        wr_ready <= 1'b0;
        wr_seen.delete();
        xfer(I2CRS_WR, 7'h01, 8'h20, 8'h11);
        xfer(I2CRS_WR, 7'h01, 8'h21, 8'h22);
        check("held valid", wr_valid, 16'h0001);
        check("held head", {wr_index, wr_data}, 16'h2011);
        @(posedge mclk_i);
        wr_ready <= 1'b1;
        for (int n = 0; n < 20 && wr_seen.size() < 2; n++) @(negedge mclk_i);
        if (wr_seen.size() < 2) give_up("drain");
        check("drain first", wr_seen.pop_front(), 16'h2011);
        check("drain second", wr_seen.pop_front(), 16'h2122);
        xfer(I2CRS_WR, 7'h01, 8'h7F, 8'h2A);
        xfer(I2CRS_WR, 7'h2A, 8'h30, 8'h5A);
        check("new address nak", nak, 16'h0000);
        xfer(I2CRS_WR, 7'h01, 8'h31, 8'h00);
        check("old address nak", nak, 16'h0001);
        @(posedge mclk_i);
        ext_rst <= 1'b1;
        repeat (3) @(posedge mclk_i);
        ext_rst <= 1'b0;
        xfer(I2CRS_WR, 7'h01, 8'h32, 8'h66);
        check("reset address nak", nak, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            pin_assign <= pa[i];
            pin_func <= pf[i];
            @(negedge mclk_i);
            check("pin out", pin_out, pa[i] & pf[i]);
        end
        wrap_up();
    end
endmodule
